// >>> include/cpu_irq_map.svh
// Purpose: Addresses, bit positions, reset values and timing for the interrupt unit
// Assumes: 12-bit register address, bank 31 starts at 0xF80
// Notes:   Summary of operation follows
`ifndef CPU_IRQ_MAP_SVH
`define CPU_IRQ_MAP_SVH

`define IRQ_ADDR_W          12
`define IRQ_CTRL_ADDR       12'h00B
`define IRQ_OPTION_ADDR     12'h095
`define IRQ_SHADOW_BASE     12'hFE4
`define IRQ_SHADOW_LAST     12'hFEB

`define IRQ_CTRL_RESET      8'h00
`define IRQ_OPTION_RESET    8'h00
`define IRQ_BIT_GLB_EN      7
`define IRQ_BIT_PER_EN      6
`define IRQ_BIT_T0IE        5
`define IRQ_BIT_EXTIE       4
`define IRQ_BIT_CHG_EN      3
`define IRQ_BIT_T0IF        2
`define IRQ_BIT_EXTIF       1
`define IRQ_BIT_CHG_SUM     0
`define IRQ_BIT_EDGE        6

`define IRQ_STATUS_KEEP     8'hE7
`define IRQ_VECTOR          15'h0004
`define IRQ_PHASE_Q1        2'h0
`define IRQ_PHASE_Q4        2'h3
`define IRQ_SHADOW_WORDS    8

`endif

// >>> include/cpu_irq_pkg.sv
// Purpose: Types shared by the interrupt unit files
// Assumes: Nothing beyond the map header
// Notes:   Constants live in cpu_irq_map.svh
package cpu_irq_pkg;
    typedef logic [7:0]  ctx_byte_t;
    typedef logic [14:0] pc_t;
    typedef logic [1:0]  phase_t;
    typedef logic [2:0]  shadow_idx_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_FLUSH = 2'b01,
        ST_FETCH = 2'b10
    } seq_state_t;
endpackage

// >>> rtl/context_shadow.sv
// Purpose: Shadow store for saved core context
// Assumes: Save and software write never in the same cycle
// Notes:   Read data registered; all words also visible in parallel
`timescale 1ns/100ps
`default_nettype none
`include "cpu_irq_map.svh"

module context_shadow
    import cpu_irq_pkg::*;
#(
    parameter int WORDS = `IRQ_SHADOW_WORDS
)(
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    input  wire logic                    save,
    input  wire logic [WORDS*8-1:0]      save_data,
    input  wire logic                    wr_en,
    input  wire cpu_irq_pkg::shadow_idx_t wr_idx,
    input  wire cpu_irq_pkg::ctx_byte_t  wr_data,
    input  wire cpu_irq_pkg::shadow_idx_t rd_idx,
    output logic [7:0]                   rd_data,
    output logic [WORDS*8-1:0]           all_data
);
    logic [WORDS*8-1:0] mem_q;
    logic [WORDS*8-1:0] mem_d;
    logic [7:0]         rd_q;
    logic [7:0]         rd_d;

    always_comb
    begin
        mem_d = mem_q;
        if (save)
            mem_d = save_data;
        else if (wr_en)
            mem_d[wr_idx*8 +: 8] = wr_data;
        rd_d = mem_q[rd_idx*8 +: 8];
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mem_q <= '0;
            rd_q  <= 8'h00;
        end
        else
        begin
            mem_q <= mem_d;
            rd_q  <= rd_d;
        end
    end

    assign rd_data  = rd_q;
    assign all_data = mem_q;
endmodule
`default_nettype wire

// >>> rtl/cpu_interrupt_unit.sv
// Purpose: Interrupt flags, enables, latency sequencing and context shadowing
// Assumes: Sequencer pulses instr_end in phase Q4 of the last cycle of an instruction
// Notes:   Four sys_clk cycles make one instruction cycle, Q1 to Q4
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_irq_map.svh"

module cpu_interrupt_unit
    import cpu_irq_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     arst_n,
    input  wire logic [`IRQ_ADDR_W-1:0]   reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [7:0]                    reg_rdata,
    input  wire logic                     ext_pin,
    input  wire logic                     timer_zero_overflow,
    input  wire logic [7:0]               port_b_change_flags,
    input  wire logic                     periph_irq_pending,
    input  wire logic                     periph_async_pending,
    input  wire logic                     instr_end,
    input  wire logic                     sleeping,
    input  wire logic                     irq_return_exec,
    input  wire cpu_irq_pkg::ctx_byte_t   live_w,
    input  wire cpu_irq_pkg::ctx_byte_t   live_status,
    input  wire cpu_irq_pkg::ctx_byte_t   live_bank_select,
    input  wire cpu_irq_pkg::ctx_byte_t   live_fsr0_lo,
    input  wire cpu_irq_pkg::ctx_byte_t   live_fsr0_hi,
    input  wire cpu_irq_pkg::ctx_byte_t   live_fsr1_lo,
    input  wire cpu_irq_pkg::ctx_byte_t   live_fsr1_hi,
    input  wire cpu_irq_pkg::ctx_byte_t   live_pc_high_latch,
    output cpu_irq_pkg::phase_t           phase,
    output logic                          irq_take,
    output logic                          stack_push,
    output logic                          stack_pop,
    output logic                          flush_prefetch,
    output logic                          nop_insert,
    output logic                          pc_load,
    output cpu_irq_pkg::pc_t              pc_load_value,
    output logic                          ctx_restore,
    output cpu_irq_pkg::ctx_byte_t        rest_w,
    output cpu_irq_pkg::ctx_byte_t        rest_status,
    output cpu_irq_pkg::ctx_byte_t        rest_bank_select,
    output cpu_irq_pkg::ctx_byte_t        rest_fsr0_lo,
    output cpu_irq_pkg::ctx_byte_t        rest_fsr0_hi,
    output cpu_irq_pkg::ctx_byte_t        rest_fsr1_lo,
    output cpu_irq_pkg::ctx_byte_t        rest_fsr1_hi,
    output cpu_irq_pkg::ctx_byte_t        rest_pc_high_latch,
    output logic                          wake_req
);
    import cpu_irq_pkg::*;

    function automatic logic in_shadow(input logic [`IRQ_ADDR_W-1:0] a);
        in_shadow = (a >= `IRQ_SHADOW_BASE) && (a <= `IRQ_SHADOW_LAST);
    endfunction

    function automatic shadow_idx_t shadow_index(input logic [`IRQ_ADDR_W-1:0] a);
        logic [`IRQ_ADDR_W-1:0] diff;
        diff = a - `IRQ_SHADOW_BASE;
        shadow_index = diff[2:0];
    endfunction

    // Registers
    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  option_q, option_d;
    phase_t      phase_q, phase_d;
    seq_state_t  state_q, state_d;
    logic [1:0]  pin_sync_q, pin_sync_d;
    logic        pin_prev_q, pin_prev_d;
    logic        edge_pend_q, edge_pend_d;
    logic        req_q, req_d;
    logic        sleep_prev_q, sleep_prev_d;
    logic        wake_hold_q, wake_hold_d;
    logic        take_q, take_d;
    logic        restore_q, restore_d;
    logic [1:0]  rsel_q, rsel_d;
    logic [7:0]  rdata_q, rdata_d;

    // Combinational helpers
    logic        ioc_summary;
    logic        edge_seen;
    logic        edge_window;
    logic        ctrl_wr;
    logic        take_now;
    logic        irq_active;
    logic        shadow_wr;
    logic [7:0]  shadow_rd;
    logic [63:0] shadow_all;
    logic [63:0] shadow_save;

    assign ioc_summary = |port_b_change_flags;

    assign edge_seen = option_q[`IRQ_BIT_EDGE] ? (pin_sync_q[1] & ~pin_prev_q)
                                               : (~pin_sync_q[1] & pin_prev_q);

    // flag may set in Q4 through Q1
    assign edge_window = (phase_q == `IRQ_PHASE_Q4) || (phase_q == `IRQ_PHASE_Q1);

    assign ctrl_wr   = reg_wr && (reg_addr == `IRQ_CTRL_ADDR);
    assign shadow_wr = reg_wr && in_shadow(reg_addr);

    // global, own and peripheral enables gate the request
    // external source needs its own enable
    assign irq_active = ctrl_q[`IRQ_BIT_GLB_EN] &&
                        ((ctrl_q[`IRQ_BIT_T0IE]  && ctrl_q[`IRQ_BIT_T0IF])  ||
                         (ctrl_q[`IRQ_BIT_EXTIE] && ctrl_q[`IRQ_BIT_EXTIF]) ||
                         (ctrl_q[`IRQ_BIT_CHG_EN] && ioc_summary)           ||
                         (ctrl_q[`IRQ_BIT_PER_EN] && periph_irq_pending));

    // take at end of instruction after a Q1 sample
    // hold off while the post-sleep instruction runs
    assign take_now = (state_q == ST_RUN) && (phase_q == `IRQ_PHASE_Q4) && instr_end &&
                      req_q && !wake_hold_q && !sleep_prev_q && ctrl_q[`IRQ_BIT_GLB_EN];

    // Phase counter and pin tracking
    always_comb
    begin
        phase_d      = phase_t'(phase_q + 2'h1);
        pin_sync_d   = {pin_sync_q[0], ext_pin};
        pin_prev_d   = pin_sync_q[1];
        sleep_prev_d = sleeping;
        // asynchronous pin passes synchroniser then waits for window
        edge_pend_d  = edge_pend_q;
        if (edge_seen)
            edge_pend_d = 1'b1;
        else if (edge_window)
            edge_pend_d = 1'b0;
        req_d = req_q;
        if (phase_q == `IRQ_PHASE_Q1)
            req_d = irq_active;
        else if (!ctrl_q[`IRQ_BIT_GLB_EN])
            req_d = 1'b0;
        // wake resumes, vector only follows through normal take
        wake_hold_d = wake_hold_q;
        if (sleep_prev_q && !sleeping)
            wake_hold_d = 1'b1;
        else if (instr_end && (phase_q == `IRQ_PHASE_Q4))
            wake_hold_d = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q      <= `IRQ_PHASE_Q1;
            pin_sync_q   <= 2'b00;
            pin_prev_q   <= 1'b0;
            sleep_prev_q <= 1'b0;
            edge_pend_q  <= 1'b0;
            req_q        <= 1'b0;
            wake_hold_q  <= 1'b0;
        end
        else
        begin
            phase_q      <= phase_d;
            pin_sync_q   <= pin_sync_d;
            pin_prev_q   <= pin_prev_d;
            sleep_prev_q <= sleep_prev_d;
            edge_pend_q  <= edge_pend_d;
            req_q        <= req_d;
            wake_hold_q  <= wake_hold_d;
        end
    end

    // Control and option registers
    always_comb
    begin
        ctrl_d   = ctrl_q;
        option_d = option_q;
        if (ctrl_wr)
            ctrl_d[7:1] = reg_wdata[7:1];
        if (reg_wr && (reg_addr == `IRQ_OPTION_ADDR))
            option_d = reg_wdata;
        // flags set regardless of enables, set beats clear
        if (timer_zero_overflow)
            ctrl_d[`IRQ_BIT_T0IF] = 1'b1;
        if ((edge_seen || edge_pend_q) && edge_window)
            ctrl_d[`IRQ_BIT_EXTIF] = 1'b1;
        if (take_now)
            ctrl_d[`IRQ_BIT_GLB_EN] = 1'b0;
        // global enable set again on return
        else if (irq_return_exec)
            ctrl_d[`IRQ_BIT_GLB_EN] = 1'b1;
        ctrl_d[`IRQ_BIT_CHG_SUM] = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q   <= `IRQ_CTRL_RESET;
            option_q <= `IRQ_OPTION_RESET;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            option_q <= option_d;
        end
    end

    // Redirect sequencer
    always_comb
    begin
        state_d   = state_q;
        take_d    = take_now;
        restore_d = irq_return_exec;
        unique case (state_q)
            ST_RUN:
                if (take_now)
                    state_d = ST_FLUSH;
            ST_FLUSH:
                if (phase_q == `IRQ_PHASE_Q4)
                    state_d = ST_FETCH;
            // second dummy cycle covers vector fetch
            ST_FETCH:
                if (phase_q == `IRQ_PHASE_Q4)
                    state_d = ST_RUN;
            default:
                state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q   <= ST_RUN;
            take_q    <= 1'b0;
            restore_q <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            take_q    <= take_d;
            restore_q <= restore_d;
        end
    end

    // flush, push and vector load on entry
    assign irq_take       = take_q;
    assign flush_prefetch = take_q;
    assign stack_push     = take_q;
    assign pc_load        = take_q;
    assign pc_load_value  = `IRQ_VECTOR;
    assign nop_insert     = (state_q != ST_RUN);
    assign stack_pop      = restore_q;
    assign ctx_restore    = restore_q;
    assign phase          = phase_q;

    // relies on firmware enabling the source first
    assign wake_req = sleeping &&
                      ((ctrl_q[`IRQ_BIT_EXTIE] && ctrl_q[`IRQ_BIT_EXTIF]) ||
                       (ctrl_q[`IRQ_BIT_CHG_EN] && ioc_summary)           ||
                       (ctrl_q[`IRQ_BIT_PER_EN] && periph_async_pending));

    // context captured with timeout and power-down masked
    assign shadow_save = {live_pc_high_latch, live_fsr1_hi, live_fsr1_lo, live_fsr0_hi,
                          live_fsr0_lo, live_bank_select,
                          live_status & `IRQ_STATUS_KEEP, live_w};

    context_shadow #(
        .WORDS     (`IRQ_SHADOW_WORDS)
    ) u_shadow (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .save      (take_now),
        .save_data (shadow_save),
        .wr_en     (shadow_wr),
        .wr_idx    (shadow_index(reg_addr)),
        .wr_data   (reg_wdata),
        .rd_idx    (shadow_index(reg_addr)),
        .rd_data   (shadow_rd),
        .all_data  (shadow_all)
    );

    // restore values come straight from shadows
    assign rest_w             = shadow_all[7:0];
    assign rest_status        = shadow_all[15:8];
    assign rest_bank_select   = shadow_all[23:16];
    assign rest_fsr0_lo       = shadow_all[31:24];
    assign rest_fsr0_hi       = shadow_all[39:32];
    assign rest_fsr1_lo       = shadow_all[47:40];
    assign rest_fsr1_hi       = shadow_all[55:48];
    assign rest_pc_high_latch = shadow_all[63:56];

    // Read path, data one cycle after strobe
    always_comb
    begin
        rsel_d  = 2'b00;
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == `IRQ_CTRL_ADDR)
            begin
                rsel_d  = 2'b01;
                rdata_d = {ctrl_q[7:1], ioc_summary};
            end
            else if (reg_addr == `IRQ_OPTION_ADDR)
            begin
                rsel_d  = 2'b01;
                rdata_d = option_q;
            end
            else if (in_shadow(reg_addr))
                rsel_d = 2'b10;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rsel_q  <= 2'b00;
            rdata_q <= 8'h00;
        end
        else
        begin
            rsel_q  <= rsel_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = (rsel_q == 2'b10) ? shadow_rd : rdata_q;
endmodule
`default_nettype wire

// >>> verif/cpu_interrupt_unit_checker.sv
// Purpose: Port assertions for the interrupt unit
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound into every cpu_interrupt_unit instance
`timescale 1ns/100ps
`default_nettype none
`include "cpu_irq_map.svh"

module cpu_irq_checker
    import cpu_irq_pkg::*;
(
    input wire logic [`IRQ_ADDR_W-1:0] reg_addr,
    input wire logic                   sys_clk,
    input wire logic                   arst_n,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    input wire logic [7:0]             port_b_change_flags,
    input wire logic                   instr_end,
    input wire logic                   sleeping,
    input wire logic                   irq_return_exec,
    input wire cpu_irq_pkg::phase_t    phase,
    input wire logic                   irq_take,
    input wire logic                   stack_push,
    input wire logic                   stack_pop,
    input wire logic                   flush_prefetch,
    input wire logic                   nop_insert,
    input wire logic                   pc_load,
    input wire cpu_irq_pkg::pc_t       pc_load_value,
    input wire logic                   ctx_restore,
    input wire cpu_irq_pkg::ctx_byte_t rest_status,
    input wire logic                   wake_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_entry;
        flush_prefetch && stack_push && pc_load && pc_load_value == `IRQ_VECTOR;
    endsequence
    sequence s_ctrl_rd;
        reg_rd && reg_addr == `IRQ_CTRL_ADDR;
    endsequence
    sequence s_return;
        stack_pop && ctx_restore;
    endsequence

    property p_take_burst; irq_take |-> s_entry; endproperty
    property p_take_cause; irq_take |-> $past(instr_end) && $past(phase) == 2'h3; endproperty
    property p_nop; irq_take |=> nop_insert [*7]; endproperty
    property p_no_retake; irq_take |=> !irq_take [*8]; endproperty
    property p_restore; irq_return_exec |=> s_return; endproperty
    property p_status_mask; ctx_restore |-> rest_status[4:3] == 2'b00; endproperty
    property p_wake; wake_req |-> sleeping; endproperty
    property p_summary;
        s_ctrl_rd ##1 $stable(port_b_change_flags) |-> reg_rdata[0] == (|port_b_change_flags);
    endproperty

    a_take_burst: assert property (p_take_burst)
        else $error("entry outputs wrong at take");
    a_take_cause: assert property (p_take_cause)
        else $error("take not after instruction end in Q4");
    a_nop: assert property (p_nop)
        else $error("dummy cycles too short");
    a_no_retake: assert property (p_no_retake)
        else $error("take during dummy cycles");
    a_restore: assert property (p_restore)
        else $error("no pop and restore after return");
    a_status_mask: assert property (p_status_mask)
        else $error("restored status carries timeout or power-down");
    a_wake: assert property (p_wake)
        else $error("wake request while awake");
    a_summary: assert property (p_summary)
        else $error("summary flag does not follow change flags");
endmodule

bind cpu_interrupt_unit cpu_irq_checker u_chk (.*);
`default_nettype wire

// >>> verif/seq_model.sv
// Purpose: Instruction sequencer stand-in for the interrupt unit
// Assumes: Every instruction takes one cycle of four phases
// Notes:   Live context is loaded by the bench or restored from shadows
`timescale 1ns/100ps
`default_nettype none

module seq_model
    import cpu_irq_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    input  wire cpu_irq_pkg::phase_t    phase,
    input  wire logic                   sleep_cmd,
    input  wire logic                   wake_req,
    input  wire logic                   load,
    input  wire cpu_irq_pkg::ctx_byte_t seed,
    input  wire logic                   ctx_restore,
    input  wire cpu_irq_pkg::ctx_byte_t rest [8],
    output logic                        instr_end,
    output logic                        sleeping,
    output cpu_irq_pkg::ctx_byte_t      live [8]
);
    assign instr_end = (phase == 2'h3) && !sleeping;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sleeping <= 1'b0;
            live <= '{default: 8'h00};
        end
        else
        begin
            if (sleep_cmd)
                sleeping <= 1'b1;
            else if (wake_req)
                sleeping <= 1'b0;
            for (int i = 0; i < 8; i++)
            begin
                if (ctx_restore)
                    live[i] <= rest[i];
                else if (load)
                    live[i] <= seed + 8'(i);
            end
            if (ctx_restore)
                live[1] <= {rest[1][7:5], live[1][4:3], rest[1][2:0]};
        end
    end
endmodule
`default_nettype wire

// >>> verif/test_cpu_interrupt_unit.sv
// Purpose: Register, entry, return and wake tests of the interrupt unit
// Assumes: Sequencer model supplies instruction ends and live context
// Notes:   Ends through give_verdict from the tests or the watchdog
`timescale 1ns/100ps
`default_nettype none
`include "cpu_irq_map.svh"

module test_cpu_interrupt_unit;
    import cpu_irq_pkg::*;
    localparam logic [11:0] CTRL = `IRQ_CTRL_ADDR;
    localparam logic [11:0] OPT = `IRQ_OPTION_ADDR;
    localparam logic [11:0] SHW = `IRQ_SHADOW_BASE;
    localparam int T0 = 0, SLP = 1, LD = 2, RET = 3;
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00, pbf = 8'h00, seed = 8'h00, reg_rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, ext_pin = 1'b0, pend = 1'b0;
    logic [3:0]  pl = 4'h0;
    logic        instr_end, sleeping, irq_take, ctx_restore, wake_req;
    phase_t      phase;
    ctx_byte_t   live [8];
    ctx_byte_t   rest [8];
    int          n_fail = 0, checks = 0, n_take = 0, n_ins = 0, k, lat, n0;

    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        if (irq_take === 1'b1) n_take++;
        if (instr_end === 1'b1) n_ins++;
    end

    cpu_interrupt_unit DUT (
        .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
        .timer_zero_overflow(pl[T0]), .port_b_change_flags(pbf), .periph_irq_pending(pend),
        .periph_async_pending(pend), .instr_end(instr_end), .sleeping(sleeping),
        .irq_return_exec(pl[RET]), .live_w(live[0]), .live_status(live[1]),
        .live_bank_select(live[2]), .live_fsr0_lo(live[3]), .live_fsr0_hi(live[4]),
        .live_fsr1_lo(live[5]), .live_fsr1_hi(live[6]), .live_pc_high_latch(live[7]),
        .phase(phase), .irq_take(irq_take), .stack_push(), .stack_pop(),
        .flush_prefetch(), .nop_insert(), .pc_load(), .pc_load_value(),
        .ctx_restore(ctx_restore), .rest_w(rest[0]), .rest_status(rest[1]),
        .rest_bank_select(rest[2]), .rest_fsr0_lo(rest[3]), .rest_fsr0_hi(rest[4]),
        .rest_fsr1_lo(rest[5]), .rest_fsr1_hi(rest[6]), .rest_pc_high_latch(rest[7]),
        .wake_req(wake_req));

    seq_model u_seq (
        .sys_clk(sys_clk), .arst_n(arst_n), .phase(phase), .sleep_cmd(pl[SLP]),
        .wake_req(wake_req), .load(pl[LD]), .seed(seed), .ctx_restore(ctx_restore),
        .rest(rest), .instr_end(instr_end), .sleeping(sleeping), .live(live));

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic pulse(input int i);
        @(posedge sys_clk) pl[i] <= 1'b1;
        @(posedge sys_clk) pl[i] <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1;
        cmp($sformatf("reg %h", a), exp, reg_rdata);
    endtask

    // Bounded wait for entry, lat counts edges
    task automatic wait_take;
        lat = 0;
        while (irq_take !== 1'b1 && lat < 40)
        begin
            @(posedge sys_clk) #1;
            lat++;
        end
    endtask

    task automatic wait_wake;
        k = 0;
        while (sleeping !== 1'b0 && k < 40)
        begin
            @(posedge sys_clk);
            k++;
        end
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        tick(3);
        arst_n <= 1'b1;
        chk(CTRL, 8'h00);
        chk(OPT, 8'h00);
        chk(12'h123, 8'h00);
        done("reset");
        wr(CTRL, 8'h01);
        chk(CTRL, 8'h00);
        @(posedge sys_clk) pbf <= 8'h10;
        chk(CTRL, 8'h01);
        @(posedge sys_clk) pbf <= 8'h00;
        done("summary");
        pulse(T0);
        tick(12);
        chk(CTRL, 8'h04);
        done("flag");
        for (k = 1; k >= 0; k--)
        begin
            wr(OPT, {1'b0, k[0], 6'h00});
            @(posedge sys_clk) ext_pin <= k[0];
            tick(10);
            wr(CTRL, 8'h00);
            @(posedge sys_clk) ext_pin <= ~k[0];
            tick(10);
            chk(CTRL, 8'h00);
            @(posedge sys_clk) ext_pin <= k[0];
            tick(6);
            chk(CTRL, 8'h02);
        end
        cmp("takes", 8'h00, 8'(n_take));
        done("edges");
        @(posedge sys_clk) seed <= 8'h30;
        pulse(LD);
        wr(CTRL, 8'hA0);
        pulse(T0);
        wait_take;
        cmp("latency", 8'h01, {7'h00, lat >= 4 && lat <= 8});
        chk(CTRL, 8'h24);
        chk(SHW, 8'h30);
        chk(SHW + 12'h1, 8'h31 & 8'hE7);
        chk(SHW + 12'h7, 8'h37);
        done("entry");
        @(posedge sys_clk) seed <= 8'h70;
        pulse(LD);
        wr(SHW, 8'h5A);
        wr(CTRL, 8'h20);
        pulse(RET);
        tick(2);
        cmp("live w", 8'h5A, live[0]);
        cmp("live status", 8'h31, live[1]);
        cmp("live bank", 8'h32, live[2]);
        chk(CTRL, 8'hA0);
        done("return");
        wr(CTRL, 8'h00);
        @(posedge sys_clk) pend <= 1'b1;
        n0 = n_take;
        wr(CTRL, 8'h80);
        tick(20);
        cmp("takes", 8'(n0), 8'(n_take));
        wr(CTRL, 8'hC0);
        wait_take;
        cmp("peripheral take", 8'h01, {7'h00, lat < 40});
        @(posedge sys_clk) pend <= 1'b0;
        done("gating");
        wr(OPT, 8'h40);
        wr(CTRL, 8'h30);
        pulse(SLP);
        pulse(T0);
        tick(10);
        cmp("asleep", 8'h01, {7'h00, sleeping});
        n0 = n_take;
        @(posedge sys_clk) ext_pin <= 1'b1;
        wait_wake;
        tick(12);
        cmp("takes", 8'(n0), 8'(n_take));
        wr(CTRL, 8'h90);
        @(posedge sys_clk) ext_pin <= 1'b0;
        pulse(SLP);
        @(posedge sys_clk) ext_pin <= 1'b1;
        wait_wake;
        n0 = n_ins;
        wait_take;
        cmp("instr before vector", 8'h01, {7'h00, n_ins > n0});
        cmp("wake take", 8'h01, {7'h00, lat < 40});
        done("sleep");
        give_verdict;
    end

    // About eighteen times the expected run
    initial
    begin
        #100000;
        n_fail++;
        give_verdict;
    end
endmodule
`default_nettype wire
